//--- rtl/dmcd_map.vh
// Purpose: constants for the dma channel control decode block
// Assumes: 32-bit ahb-lite register bus, word aligned registers
// Notes:   offsets are byte addresses, decoded on haddr[4:2]
`ifndef DMCD_MAP_VH
`define DMCD_MAP_VH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define DMCD_IDX_CTRL0      3'h0
`define DMCD_IDX_CTRL1      3'h1
`define DMCD_IDX_CTRL2      3'h2
`define DMCD_IDX_CTRL3      3'h3
`define DMCD_IDX_MODE       3'h4
`define DMCD_IDX_STAT       3'h5

// ----------------------------------------------------------------
// reset values and write masks
// ----------------------------------------------------------------
`define DMCD_CTRL_RESET     32'h00000000
`define DMCD_CTRL_WMASK01   32'hff0ffff5
`define DMCD_CTRL_WMASK23   32'hff0afff5

// ----------------------------------------------------------------
// channel control field positions
// ----------------------------------------------------------------
`define DMCD_SSA_HI         31
`define DMCD_SSA_LO         29
`define DMCD_STC_BIT        28
`define DMCD_DSA_HI         27
`define DMCD_DSA_LO         25
`define DMCD_DTC_BIT        24
`define DMCD_DS_BIT         19
`define DMCD_RL_BIT         18
`define DMCD_AM_BIT         17
`define DMCD_AL_BIT         16
`define DMCD_DM_HI          15
`define DMCD_DM_LO          14
`define DMCD_SM_HI          13
`define DMCD_SM_LO          12
`define DMCD_RS_HI          11
`define DMCD_RS_LO          8
`define DMCD_TM_BIT         7
`define DMCD_TS_HI          6
`define DMCD_TS_LO          4
`define DMCD_TE_BIT         1
`define DMCD_MODE_DDT_BIT   0

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define DMCD_RS_EXT_DUAL    4'h0
`define DMCD_RS_EXT_MEM2DEV 4'h2
`define DMCD_RS_EXT_DEV2MEM 4'h3
`define DMCD_AM_FIXED       2'h0
`define DMCD_AM_INC         2'h1
`define DMCD_AM_DEC         2'h2
`define DMCD_TS_QUAD        3'h0
`define DMCD_TS_BYTE        3'h1
`define DMCD_TS_WORD        3'h2
`define DMCD_TS_LONG        3'h3
`define DMCD_TS_BLK32       3'h4
`define DMCD_STEP_QUAD      8'h08
`define DMCD_STEP_BYTE      8'h01
`define DMCD_STEP_WORD      8'h02
`define DMCD_STEP_LONG      8'h04
`define DMCD_STEP_BLK32     8'h20

`endif

//--- rtl/dmcd_req_sense.v
// Purpose: request pin synchroniser with low-level or falling-edge sensing
// Assumes: pin is asynchronous to clk_in
// Notes:   edge requests stay pending until taken; a new edge beats the clear
`timescale 1ns/1ps
module dmcd_req_sense (
  input  wire clk_in,
  input  wire rst_in,
  input  wire ce_in,
  input  wire pin_in,
  input  wire edge_mode_in,
  input  wire enable_in,
  input  wire clear_in,
  output reg  req_out
);
  reg sync1;
  reg sync2;
  reg sync3;
  reg pending;
  wire fall;
  reg  next_pending;

  assign fall = sync3 & ~sync2;

  always @* begin
    next_pending = pending;
    if (clear_in) begin
      next_pending = 1'b0;
    end
    if (fall & enable_in & edge_mode_in) begin
      next_pending = 1'b1;
    end
    if (~enable_in | ~edge_mode_in) begin
      next_pending = 1'b0;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      sync1   <= 1'b1;
      sync2   <= 1'b1;
      sync3   <= 1'b1;
      pending <= 1'b0;
      req_out <= 1'b0;
    end else if (ce_in) begin
      sync1   <= pin_in;
      sync2   <= sync1;
      sync3   <= sync2;
      pending <= next_pending;
      // level mode follows the pin low level, edge mode the pending flag
      req_out <= enable_in & (edge_mode_in ? next_pending : ~sync2);
    end
  end
endmodule

//--- rtl/dmcd_top.v
// Purpose: dma channel control registers and their per-channel decode
// Assumes: ahb-lite single word transfers, one clock, sync reset
// Notes:   four channels; channel n uses the field at n times the field width in each flat bus
//
// Function
// - source space attribute selects card access type
// - destination attribute same encoding, reset reserved
// - source wait select: area5 or area6
// - destination wait select: area5 or area6
// - bits 23 to 20 read zero
// - request sense: low level or falling edge
// - sense valid ch0-1 normal, all direct
// - burst mode: level or edge burst
// - accept output polarity from check-level bit
// - check level only ch0-1 normal mode
// - ack in read or write; single always
// - ack mode ch0-1 normal, ch1-3 direct
// - ack polarity bit, ch0-1 normal only
// - destination step fixed, increment, decrement by size
// - memory to device ignores destination mode
// - device to memory ignores source mode
// - source step fixed, increment, decrement by size
// - ch2-3 polarity bits absent, read zero
// - attributes apply only to card areas
`timescale 1ns/1ps
`include "dmcd_map.vh"
module dmcd_top (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        ce_in,
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output reg  [31:0] hrdata_out,
  output wire        hreadyout_out,
  output wire        hresp_out,
  input  wire [3:0]  xfer_request_pin_in,
  input  wire [3:0]  grant_in,
  input  wire [3:0]  rd_cycle_in,
  input  wire [3:0]  wr_cycle_in,
  input  wire [3:0]  src_card_hit_in,
  input  wire [3:0]  dst_card_hit_in,
  output wire [3:0]  xfer_req_out,
  output reg  [3:0]  burst_level_out,
  output reg  [3:0]  burst_edge_out,
  output reg  [3:0]  request_accept_out,
  output reg  [3:0]  xfer_acknowledge_pin_out,
  output reg  [3:0]  direct_mode_ack_out,
  output reg  [11:0] src_space_attr_out,
  output reg  [11:0] dst_space_attr_out,
  output reg  [3:0]  src_wait_area6_out,
  output reg  [3:0]  dst_wait_area6_out,
  output reg  [31:0] src_step_out,
  output reg  [31:0] dst_step_out,
  output reg  [3:0]  step_mode_error_out
);

  // ----------------------------------------------------------------
  // step size from address mode and transfer size
  // ----------------------------------------------------------------
  function [7:0] step_of;
    input [1:0] mode;
    input [2:0] size;
    reg   [7:0] mag;
    begin
      case (size)
        `DMCD_TS_QUAD:  mag = `DMCD_STEP_QUAD;
        `DMCD_TS_BYTE:  mag = `DMCD_STEP_BYTE;
        `DMCD_TS_WORD:  mag = `DMCD_STEP_WORD;
        `DMCD_TS_LONG:  mag = `DMCD_STEP_LONG;
        `DMCD_TS_BLK32: mag = `DMCD_STEP_BLK32;
        default:        mag = 8'h00;
      endcase
      case (mode)
        `DMCD_AM_INC: step_of = mag;
        `DMCD_AM_DEC: step_of = 8'h00 - mag;
        default:      step_of = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  reg  [31:0] ctrl [0:3];
  reg         ddt_mode;
  reg         dp_write;
  reg  [2:0]  dp_idx;
  reg  [31:0] next_rdata;
  wire        take;
  wire [2:0]  ap_idx;
  wire [1:0]  wr_ch;
  wire [31:0] wr_mask;
  wire [31:0] wr_value;
  wire        fwd_hit;
  integer     i;

  assign take          = hsel_in & htrans_in[1] & hready_in & ce_in;
  assign hreadyout_out = ce_in;
  assign hresp_out     = 1'b0;

  assign ap_idx        = haddr_in[4:2];
  assign wr_ch         = dp_idx[1:0];
  // reserved bits forced low; channels 2-3 lack two polarity bits
  assign wr_mask       = wr_ch[1] ? `DMCD_CTRL_WMASK23 : `DMCD_CTRL_WMASK01;
  // the completion flag can only be cleared from the bus
  assign wr_value      = (hwdata_in & wr_mask) |
                         {30'h0, ctrl[wr_ch][`DMCD_TE_BIT] & hwdata_in[`DMCD_TE_BIT], 1'b0};
  assign fwd_hit       = dp_write & (dp_idx == ap_idx);

  always @(posedge clk_in) begin
    if (rst_in) begin
      dp_write <= 1'b0;
      dp_idx   <= 3'h0;
    end else if (ce_in) begin
      dp_write <= take & hwrite_in;
      if (take) begin
        dp_idx <= haddr_in[4:2];
      end
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      for (i = 0; i < 4; i = i + 1) begin
        ctrl[i] <= `DMCD_CTRL_RESET;
      end
    end else if (ce_in & dp_write & ~dp_idx[2]) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (wr_ch == i[1:0]) begin
          ctrl[i] <= wr_value;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      ddt_mode <= 1'b0;
    end else if (ce_in & dp_write & (dp_idx == `DMCD_IDX_MODE)) begin
      ddt_mode <= hwdata_in[`DMCD_MODE_DDT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // read data, captured at the address phase, held for the data phase
  // ----------------------------------------------------------------
  always @* begin
    next_rdata = 32'h00000000;
    case (ap_idx)
      `DMCD_IDX_CTRL0: next_rdata = ctrl[0];
      `DMCD_IDX_CTRL1: next_rdata = ctrl[1];
      `DMCD_IDX_CTRL2: next_rdata = ctrl[2];
      `DMCD_IDX_CTRL3: next_rdata = ctrl[3];
      `DMCD_IDX_MODE:  next_rdata = {31'h0, ddt_mode};
      `DMCD_IDX_STAT:  next_rdata = {28'h0, xfer_req_out};
      default:         next_rdata = 32'h00000000;
    endcase
    // a write still in its data phase lands on this same edge
    if (fwd_hit & ~ap_idx[2]) begin
      next_rdata = wr_value;
    end
    if (fwd_hit & (ap_idx == `DMCD_IDX_MODE)) begin
      next_rdata = {31'h0, hwdata_in[`DMCD_MODE_DDT_BIT]};
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h00000000;
    end else if (ce_in) begin
      hrdata_out <= (take & ~hwrite_in) ? next_rdata : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // per-channel decode
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
      wire [31:0] c;
      wire [3:0]  rs;
      wire        ext_req;
      wire        single_m2d;
      wire        single_d2m;
      wire        sense_ok;
      wire        pol_ok;
      wire        am_ok;
      wire        ds_eff;
      wire        rl_eff;
      wire        am_eff;
      wire        al_eff;
      wire        ack_act;
      wire [1:0]  dm;
      wire [1:0]  sm;
      wire [7:0]  next_src_step;
      wire [7:0]  next_dst_step;
      wire        next_step_err;

      assign c          = ctrl[ch];
      assign rs         = c[`DMCD_RS_HI:`DMCD_RS_LO];
      assign single_m2d = (rs == `DMCD_RS_EXT_MEM2DEV);
      assign single_d2m = (rs == `DMCD_RS_EXT_DEV2MEM);
      assign ext_req    = (rs == `DMCD_RS_EXT_DUAL) | single_m2d | single_d2m;
      assign sense_ok   = ddt_mode | (ch < 2);
      assign pol_ok     = ~ddt_mode & (ch < 2);
      assign am_ok      = ddt_mode ? (ch > 0) : (ch < 2);
      assign ds_eff     = sense_ok & c[`DMCD_DS_BIT];
      assign rl_eff     = pol_ok & c[`DMCD_RL_BIT];
      assign am_eff     = am_ok & c[`DMCD_AM_BIT];
      assign al_eff     = pol_ok & c[`DMCD_AL_BIT];
      // single address mode acknowledges both phases
      assign ack_act    = (single_m2d | single_d2m) ?
                          (rd_cycle_in[ch] | wr_cycle_in[ch]) :
                          (am_eff ? wr_cycle_in[ch] : rd_cycle_in[ch]);
      assign dm         = c[`DMCD_DM_HI:`DMCD_DM_LO];
      assign sm         = c[`DMCD_SM_HI:`DMCD_SM_LO];
      assign next_src_step = single_d2m ? 8'h00 :
                             step_of(sm, c[`DMCD_TS_HI:`DMCD_TS_LO]);
      assign next_dst_step = single_m2d ? 8'h00 :
                             step_of(dm, c[`DMCD_TS_HI:`DMCD_TS_LO]);
      assign next_step_err = (~single_d2m & (sm == 2'h3)) | (~single_m2d & (dm == 2'h3));

      dmcd_req_sense i_dmcd_req_sense (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .ce_in        (ce_in),
        .pin_in       (xfer_request_pin_in[ch]),
        .edge_mode_in (ds_eff),
        .enable_in    (ext_req & sense_ok),
        .clear_in     (grant_in[ch]),
        .req_out      (xfer_req_out[ch])
      );

      // ----------------------------------------------------------------
      // request, accept and acknowledge pins
      // ----------------------------------------------------------------
      always @(posedge clk_in) begin
        if (rst_in) begin
          burst_level_out[ch]          <= 1'b0;
          burst_edge_out[ch]           <= 1'b0;
          request_accept_out[ch]       <= 1'b0;
          xfer_acknowledge_pin_out[ch] <= 1'b0;
          direct_mode_ack_out[ch]      <= 1'b0;
        end else if (ce_in) begin
          burst_level_out[ch] <= c[`DMCD_TM_BIT] & ~ds_eff;
          burst_edge_out[ch]  <= c[`DMCD_TM_BIT] & ds_eff;
          request_accept_out[ch] <= grant_in[ch] ^ rl_eff;
          xfer_acknowledge_pin_out[ch] <= (~ddt_mode & ack_act) ^ al_eff;
          direct_mode_ack_out[ch] <= ddt_mode & am_ok & ack_act;
        end
      end

      // ----------------------------------------------------------------
      // card attributes and wait selection
      // ----------------------------------------------------------------
      always @(posedge clk_in) begin
        if (rst_in) begin
          src_space_attr_out[3*ch+2:3*ch] <= 3'h0;
          dst_space_attr_out[3*ch+2:3*ch] <= 3'h0;
          src_wait_area6_out[ch]       <= 1'b0;
          dst_wait_area6_out[ch]       <= 1'b0;
        end else if (ce_in) begin
          // card attributes only drive while the access hits a card area
          src_space_attr_out[3*ch+2:3*ch] <= src_card_hit_in[ch] ?
              c[`DMCD_SSA_HI:`DMCD_SSA_LO] : 3'h0;
          dst_space_attr_out[3*ch+2:3*ch] <= dst_card_hit_in[ch] ?
              c[`DMCD_DSA_HI:`DMCD_DSA_LO] : 3'h0;
          src_wait_area6_out[ch] <= src_card_hit_in[ch] & c[`DMCD_STC_BIT];
          dst_wait_area6_out[ch] <= dst_card_hit_in[ch] & c[`DMCD_DTC_BIT];
        end
      end

      // ----------------------------------------------------------------
      // address stepping
      // ----------------------------------------------------------------
      always @(posedge clk_in) begin
        if (rst_in) begin
          src_step_out[8*ch+7:8*ch]    <= 8'h00;
          dst_step_out[8*ch+7:8*ch]    <= 8'h00;
          step_mode_error_out[ch]      <= 1'b0;
        end else if (ce_in) begin
          src_step_out[8*ch+7:8*ch]    <= next_src_step;
          dst_step_out[8*ch+7:8*ch]    <= next_dst_step;
          step_mode_error_out[ch]      <= next_step_err;
        end
      end
    end
  endgenerate

endmodule

//--- dv/dmcd_monitor.sv
// Purpose: port-level checks on the dma control decode block
// Assumes: one clock, synchronous active-high reset
// Notes:   attached to dmcd_top by the bind at the foot
`timescale 1ns/1ps
module dmcd_monitor (
  input wire        clk_in,
  input wire        rst_in,
  input wire        ce_in,
  input wire        hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0]  htrans_in,
  input wire        hwrite_in,
  input wire [31:0] hrdata_out,
  input wire        hreadyout_out,
  input wire        hresp_out,
  input wire [3:0]  grant_in,
  input wire [3:0]  src_card_hit_in,
  input wire [3:0]  dst_card_hit_in,
  input wire [3:0]  request_accept_out,
  input wire [3:0]  burst_level_out,
  input wire [3:0]  burst_edge_out,
  input wire [3:0]  direct_mode_ack_out,
  input wire [11:0] src_space_attr_out,
  input wire [11:0] dst_space_attr_out,
  input wire [3:0]  src_wait_area6_out,
  input wire [3:0]  dst_wait_area6_out
);
  reg       rd_ph;
  reg [2:0] rd_ix;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------------------------------
  // read data phase tracker
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rst_in) begin
      rd_ph <= 1'b0;
    end else if (ce_in) begin
      rd_ph <= hsel_in & htrans_in[1] & hreadyout_out & ~hwrite_in;
      rd_ix <= haddr_in[4:2];
    end
  end
  a_resp_okay: assert property (hresp_out == 1'b0) else $error("response not okay");
  a_ready_ce: assert property (hreadyout_out == ce_in) else $error("ready not clock enable");
  a_rsvd_zero: assert property (rd_ph |-> hrdata_out[23:20] == 4'h0)
    else $error("reserved bits read nonzero");
  a_absent_bits: assert property (rd_ph && rd_ix[2:1] == 2'h1 |->
    !hrdata_out[18] && !hrdata_out[16]) else $error("absent bits read set");
  a_unmap_zero: assert property (rd_ph && rd_ix[2:1] == 2'h3 |-> hrdata_out == 32'h0)
    else $error("unmapped read nonzero");
  a_accept_fixed: assert property (ce_in |=>
    request_accept_out[3:2] == $past(grant_in[3:2])) else $error("accept polarity wrong");
  a_src_nohit: assert property (ce_in && src_card_hit_in == 4'h0 |=>
    src_space_attr_out == 12'h0 && src_wait_area6_out == 4'h0) else $error("src attr leak");
  a_dst_nohit: assert property (ce_in && dst_card_hit_in == 4'h0 |=>
    dst_space_attr_out == 12'h0 && dst_wait_area6_out == 4'h0) else $error("dst attr leak");
  a_burst_one: assert property ((burst_level_out & burst_edge_out) == 4'h0)
    else $error("both burst kinds");
  a_direct_ack0: assert property (direct_mode_ack_out[0] == 1'b0)
    else $error("direct ack on channel 0");
endmodule
bind dmcd_top dmcd_monitor i_dmcd_monitor (.*);

//--- dv/dmcd_peer.sv
// Purpose: external requester on the four request pins
// Assumes: pins idle high through a pull-up, requests active low
// Notes:   a pulse command gives a two-cycle low pulse, one falling edge
`timescale 1ns/1ps
module dmcd_peer (
  input  wire       clk_in,
  input  wire [3:0] hold_in,
  input  wire [3:0] pulse_in,
  output reg  [3:0] pin_out
);
  reg [3:0] pulse_q = 4'h0;
  initial pin_out = 4'hf;
  // ----------------------------------------------------------------
  // pins move off the edge, the device treats them as asynchronous
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    pulse_q <= pulse_in;
    pin_out <= #7 ~(hold_in | pulse_in | pulse_q);
  end
endmodule

//--- dv/dmcd_top_tb_top.sv
// Purpose: self-checking bench for dmcd_top
// Assumes: zero-wait ahb-lite slave, peer model on the request pins
// Notes:   one task per scenario
`timescale 1ns/1ps
module dmcd_top_tb_top;
  logic        clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, q;
  logic [1:0]  htrans_in = 2'h0;
  logic [2:0]  hsize_in = 3'h2;
  logic [3:0]  grant_in = 4'h0, rd_cycle_in = 4'h0, wr_cycle_in = 4'h0, hold = 4'h0;
  logic [3:0]  src_card_hit_in = 4'h0, dst_card_hit_in = 4'h0, pulse = 4'h0;
  logic [7:0]  ns, stp [5] = '{8'h08, 8'h01, 8'h02, 8'h04, 8'h20};
  wire  [3:0]  xfer_request_pin_in, xfer_req_out, burst_level_out, burst_edge_out;
  wire  [3:0]  request_accept_out, xfer_acknowledge_pin_out, direct_mode_ack_out;
  wire  [3:0]  src_wait_area6_out, dst_wait_area6_out, step_mode_error_out;
  wire  [11:0] src_space_attr_out, dst_space_attr_out;
  wire  [31:0] hrdata_out, src_step_out, dst_step_out;
  wire         hreadyout_out, hresp_out;
  wire         hready_in = hreadyout_out;
  int          errors = 0, check_count = 0, i;
  always #20 clk_in = ~clk_in;
  dmcd_top i_dmcd_top (.*);
  dmcd_peer i_dmcd_peer (.clk_in(clk_in), .hold_in(hold), .pulse_in(pulse),
                         .pin_out(xfer_request_pin_in));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input [31:0] s, input [31:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task final_report;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task cy(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task bus(input [31:0] a, input w, input [31:0] d, output [31:0] rq);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    haddr_in <= a;
    hwrite_in <= w;
    htrans_in <= 2'h2;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    @(posedge clk_in);
    while (hreadyout_out !== 1'b1) @(posedge clk_in);
    rq = hrdata_out;
  endtask
  task wr(input [31:0] a, input [31:0] d);
    bus(a, 1'b1, d, q);
    cy(3);
  endtask
  task rd(input [31:0] a, input [31:0] e);
    bus(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    for (i = 0; i < 4; i++) rd(i * 4, 32'h0);
    wr(32'h0, 32'hff0fffff);
    rd(32'h0, 32'hff0ffff5);
    wr(32'h8, 32'hff0fffff);
    rd(32'h8, 32'hff0afff5);
    wr(32'h18, 32'hffffffff);
    rd(32'h18, 32'h0);
    wr(32'h0, 32'h0);
    wr(32'h8, 32'h0);
    ce_in <= 1'b0;
    cy(3);
    chk(hreadyout_out, 1'b0);
    ce_in <= 1'b1;
    $display("regs done");
  endtask
  task t_attr;
    src_card_hit_in <= 4'h1;
    dst_card_hit_in <= 4'h1;
    for (i = 0; i < 8; i++) begin
      wr(32'h0, (i << 29) | (i[0] << 28) | ((7 - i) << 25) | (!i[0] << 24));
      chk(src_space_attr_out[2:0], i);
      chk(dst_space_attr_out[2:0], 7 - i);
      chk(src_wait_area6_out[0], i[0]);
      chk(dst_wait_area6_out[0], !i[0]);
    end
    src_card_hit_in <= 4'h0;
    dst_card_hit_in <= 4'h0;
    cy(3);
    chk(src_space_attr_out, 12'h0);
    $display("attr done");
  endtask
  task t_step;
    for (i = 0; i < 5; i++) begin
      ns = 8'h0 - stp[i];
      wr(32'h0, 32'h6000 | (i << 4));
      chk(dst_step_out[7:0], stp[i]);
      chk(src_step_out[7:0], ns);
    end
    wr(32'h0, 32'h5210);
    chk(dst_step_out[7:0], 8'h0);
    chk(src_step_out[7:0], 8'h01);
    wr(32'h0, 32'h5310);
    chk(src_step_out[7:0], 8'h0);
    chk(dst_step_out[7:0], 8'h01);
    wr(32'h0, 32'hc000);
    chk(step_mode_error_out[0], 1'b1);
    wr(32'h0, 32'h0);
    $display("step done");
  endtask
  task t_req;
    hold <= 4'h1;
    cy(6);
    chk(xfer_req_out[0], 1'b1);
    hold <= 4'h0;
    cy(6);
    chk(xfer_req_out[0], 1'b0);
    wr(32'h0, 32'h80000);
    pulse <= 4'h1;
    cy(1);
    pulse <= 4'h0;
    cy(8);
    chk(xfer_req_out[0], 1'b1);
    rd(32'h14, 32'h1);
    grant_in <= 4'h1;
    cy(1);
    grant_in <= 4'h0;
    cy(3);
    chk(xfer_req_out[0], 1'b0);
    wr(32'h0, 32'h80);
    chk(burst_level_out[0], 1'b1);
    wr(32'h0, 32'h80080);
    chk(burst_edge_out[0], 1'b1);
    hold <= 4'h4;
    cy(6);
    chk(xfer_req_out[2], 1'b0);
    wr(32'h10, 32'h1);
    cy(3);
    chk(xfer_req_out[2], 1'b1);
    hold <= 4'h0;
    wr(32'h10, 32'h0);
    $display("req done");
  endtask
  task t_ack;
    wr(32'h0, 32'h50000);
    chk(request_accept_out[0], 1'b1);
    grant_in <= 4'h1;
    cy(1);
    grant_in <= 4'h0;
    #1;
    chk(request_accept_out[0], 1'b0);
    cy(1);
    rd_cycle_in <= 4'h1;
    cy(2);
    chk(xfer_acknowledge_pin_out[0], 1'b0);
    rd_cycle_in <= 4'h0;
    wr_cycle_in <= 4'h1;
    cy(2);
    chk(xfer_acknowledge_pin_out[0], 1'b1);
    wr(32'h0, 32'h70000);
    chk(xfer_acknowledge_pin_out[0], 1'b0);
    wr(32'h0, 32'h50200);
    chk(xfer_acknowledge_pin_out[0], 1'b0);
    wr(32'h10, 32'h1);
    wr(32'h4, 32'h20000);
    wr_cycle_in <= 4'h2;
    cy(3);
    chk(direct_mode_ack_out[1], 1'b1);
    chk(request_accept_out[0], 1'b0);
    chk(xfer_acknowledge_pin_out[0], 1'b0);
    $display("ack done");
  endtask
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs;
    t_attr;
    t_step;
    t_req;
    t_ack;
    final_report;
  end
  initial begin
    #400000;
    errors++;
    final_report;
  end
endmodule
